// ==== design/otp_parameter_store.sv ====
// Fuse parameter store: burn, read-back, reload and decoded outputs
// Contract
// R1: Eight fuse bytes, fixed field layout at addresses 0 to 7.
// R2: Unburned bits read 0; burning sets a bit to 1 forever.
// R3: Burning a bit already at 1 has no effect.
// R4: Each burn command targets exactly one byte.
// R5: User guard set blocks burning of all eight bytes.
// R6: Factory guard blocks burning of bytes 0 and 1.
// R7: Bytes 0 and 1 hold factory calibration trims.
// R8: Master verifies settings in RAM before burning.
// R9: Read-back returns one fuse byte.
// R10: New bits take effect only after read-back, reload or power-up; the code applies guard bits to burning at once.
// R11: All parameters but node id bits are RAM-overridable.
// R12: Node id is four fuse bits plus three pin bits.
// R13: Fuse bits are the upper four node id bits.
// R14: Absolute stall level is code times 0.5 V, zero disables.
// R15: Change stall level is code times 0.25 V, zero disables.
// R16: Run current ladder 59 mA to 800 mA.
// R17: Hold current same ladder, code 15 gives zero.
// R18: Microstep field selects half to sixteenth stepping.
// R19: Shaft bit selects inner or outer reference.
// R20: Fallback code 0x400 disables fallback motion.
// R21: Fallback supplies eleven upper bits, five low bits zero.
// R22: Top speed ladder; floor speed is top times code/32 or 1.
// R23: Ramp rate ladder 49 to 40047 steps per second squared.
// R24: Auto-doze bit sends device to sleep on bus timeout.
// R25: Rescue bit starts fallback motion on bus loss at power-on.
`timescale 1ns/1ps
module otp_parameter_store (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic nvm_burn_command,
  input wire logic [2:0] burn_addr,
  input wire logic [7:0] burn_data,
  input wire logic nvm_readback_command,
  input wire logic [2:0] readback_addr,
  input wire logic defaults_reload_command,
  input wire logic [2:0] pin_node_id_bits,
  input wire logic bus_timeout,
  input wire logic bus_lost_at_por,
  output logic burn_busy,
  output logic burn_refused,
  output logic burn_done,
  output logic readback_valid,
  output logic [7:0] readback_data,
  output logic [6:0] node_id,
  output logic [3:0] clock_trim,
  output logic [3:0] bias_current_trim,
  output logic [2:0] overheat_limit_trim,
  output logic [3:0] voltage_ref_trim,
  output logic bus_transceiver_on,
  output logic [9:0] stall_level_absolute,
  output logic [9:0] stall_level_change,
  output logic [9:0] run_current_ma,
  output logic [9:0] hold_current_ma,
  output logic [9:0] top_speed_fs,
  output logic [9:0] floor_speed_fs,
  output logic [15:0] ramp_rate_fs2,
  output logic [15:0] fallback_target,
  output logic fallback_enable,
  output logic [1:0] microstep_resolution,
  output logic shaft_outer,
  output logic sleep_request,
  output logic rescue_motion_start
);
  import otp_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BURN = 3'b010,
    ST_LOAD = 3'b100
  } state_e;

  burn_if fz ();
  state_e state_r;
  logic [7:0] act_r [8];
  logic [2:0] pin_s1_id_r;
  logic [2:0] pin_s2_r;
  logic start_r;
  logic [2:0] addr_r;
  logic [7:0] mask_r;
  logic load_pending_r;
  logic booted_r;
  logic timeout_s1_r;
  logic timeout_s2_r;
  logic lost_s1_r;
  logic lost_s2_r;
  logic blocked;
  logic load_req;

  logic [6:0] dec_node;
  centivolt_t dec_abs;
  centivolt_t dec_del;
  milliamp_t dec_run;
  milliamp_t dec_hold;
  velocity_t dec_vmax;
  velocity_t dec_vmin;
  accel_t dec_acc;
  logic [15:0] dec_fb;
  logic dec_fb_en;
  logic [1:0] dec_step;
  logic dec_shaft;

  fuse_array u_fuses (
    .mclk(mclk),
    .rst_n(rst_n),
    .bus(fz.array)
  );

  param_decode u_dec (
    .act(act_r),
    .pin_node_id_bits(pin_s2_r),
    .node_id(dec_node),
    .abs_cv(dec_abs),
    .del_cv(dec_del),
    .run_ma(dec_run),
    .hold_ma(dec_hold),
    .vmax(dec_vmax),
    .vmin(dec_vmin),
    .accel(dec_acc),
    .fallback_pos(dec_fb),
    .fallback_en(dec_fb_en),
    .microstep_resolution(dec_step),
    .shaft_outer(dec_shaft)
  );

  assign fz.start = start_r;
  assign fz.addr = addr_r;
  assign fz.mask = mask_r;

  // Guards are read from the live fuses so a fresh guard burn locks at once
  assign blocked = fz.bytes[ADDR_GUARDS][USER_GUARD_BIT] || // R5
    (fz.bytes[ADDR_GUARDS][FACTORY_GUARD_BIT] && burn_addr <= FACTORY_LAST_ADDR); // R6
  assign load_req = nvm_readback_command || defaults_reload_command || !booted_r;

  // Pin and status inputs come from outside the clock domain
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_s1_id_r <= 3'h0;
      pin_s2_r <= 3'h0;
      timeout_s1_r <= 1'b0;
      timeout_s2_r <= 1'b0;
      lost_s1_r <= 1'b0;
      lost_s2_r <= 1'b0;
    end else begin
      pin_s1_id_r <= pin_node_id_bits;
      pin_s2_r <= pin_s1_id_r;
      timeout_s1_r <= bus_timeout;
      timeout_s2_r <= timeout_s1_r;
      lost_s1_r <= bus_lost_at_por;
      lost_s2_r <= lost_s1_r;
    end
  end

  // Command sequencing; a burn in flight defers any load until it finishes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      start_r <= 1'b0;
      addr_r <= ADDR_CLK_BIAS;
      mask_r <= BYTE_ZERO;
      burn_refused <= 1'b0;
      burn_done <= 1'b0;
      burn_busy <= 1'b0;
      load_pending_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      burn_refused <= 1'b0;
      burn_done <= 1'b0;
      if (load_req && state_r != ST_IDLE) begin
        load_pending_r <= 1'b1;
      end
      unique case (state_r)
        ST_IDLE: begin
          if (load_req || load_pending_r) begin
            state_r <= ST_LOAD;
            load_pending_r <= 1'b0;
          end else if (nvm_burn_command) begin
            if (blocked) begin
              burn_refused <= 1'b1;
            end else begin
              state_r <= ST_BURN; // R4
              start_r <= 1'b1;
              addr_r <= burn_addr;
              mask_r <= burn_data;
              burn_busy <= 1'b1;
            end
          end
        end
        ST_BURN: begin
          if (fz.done) begin
            state_r <= ST_IDLE;
            burn_busy <= 1'b0;
            burn_done <= 1'b1;
          end
        end
        ST_LOAD: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Active copy: burned bits stay inactive until a load
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      booted_r <= 1'b0;
      for (int i = 0; i < NUM_BYTES; i++) begin
        act_r[i] <= BYTE_ZERO;
      end
    end else if (state_r == ST_LOAD) begin
      booted_r <= 1'b1;
      act_r <= fz.bytes; // R10
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      readback_valid <= 1'b0;
      readback_data <= BYTE_ZERO;
    end else begin
      readback_valid <= 1'b0;
      if (nvm_readback_command && state_r == ST_IDLE) begin
        readback_valid <= 1'b1;
        readback_data <= fz.bytes[readback_addr]; // R9
      end
    end
  end

  // Registered parameter outputs; RAM overrides live downstream
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      node_id <= 7'h00;
      clock_trim <= CODE_OFF;
      bias_current_trim <= CODE_OFF;
      overheat_limit_trim <= 3'h0;
      voltage_ref_trim <= CODE_OFF;
      bus_transceiver_on <= 1'b0;
      stall_level_absolute <= 10'h000;
      stall_level_change <= 10'h000;
      run_current_ma <= 10'h000;
      hold_current_ma <= 10'h000;
      top_speed_fs <= 10'h000;
      floor_speed_fs <= 10'h000;
      ramp_rate_fs2 <= 16'h0000;
      fallback_target <= 16'h0000;
      fallback_enable <= 1'b0;
      microstep_resolution <= 2'b00;
      shaft_outer <= 1'b0;
    end else begin
      node_id <= dec_node; // R11 R12
      clock_trim <= act_r[ADDR_CLK_BIAS][7:4]; // R7
      bias_current_trim <= act_r[ADDR_CLK_BIAS][3:0]; // R7
      overheat_limit_trim <= act_r[ADDR_BUS_REF][6:4]; // R7
      voltage_ref_trim <= act_r[ADDR_BUS_REF][3:0]; // R7
      bus_transceiver_on <= act_r[ADDR_BUS_REF][7]; // R7
      stall_level_absolute <= dec_abs;
      stall_level_change <= dec_del;
      run_current_ma <= dec_run;
      hold_current_ma <= dec_hold;
      top_speed_fs <= dec_vmax;
      floor_speed_fs <= dec_vmin;
      ramp_rate_fs2 <= dec_acc;
      fallback_target <= dec_fb;
      fallback_enable <= dec_fb_en;
      microstep_resolution <= dec_step;
      shaft_outer <= dec_shaft;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sleep_request <= 1'b0;
      rescue_motion_start <= 1'b0;
    end else begin
      sleep_request <= timeout_s2_r && act_r[ADDR_FB_LOW][0]; // R24
      rescue_motion_start <= lost_s2_r && act_r[ADDR_FB_LOW][1] && booted_r; // R25
    end
  end

  property p_refuse_user_guard;
    @(posedge mclk) disable iff (!rst_n)
      (state_r == ST_IDLE && !load_req && !load_pending_r && nvm_burn_command &&
       fz.bytes[ADDR_GUARDS][USER_GUARD_BIT]) |=> burn_refused && !start_r;
  endproperty
  a_refuse_user_guard: assert property (p_refuse_user_guard) // R5
    else $error("burn accepted with user guard set");

  property p_refuse_factory;
    @(posedge mclk) disable iff (!rst_n)
      (state_r == ST_IDLE && !load_req && !load_pending_r && nvm_burn_command &&
       fz.bytes[ADDR_GUARDS][FACTORY_GUARD_BIT] && burn_addr <= FACTORY_LAST_ADDR)
      |=> burn_refused;
  endproperty
  a_refuse_factory: assert property (p_refuse_factory) // R6
    else $error("factory bytes burn not refused");

  property p_bits_only_set;
    @(posedge mclk) disable iff (!rst_n)
      1'b1 |=> ((fz.bytes[ADDR_GUARDS] & $past(fz.bytes[ADDR_GUARDS])) ==
                $past(fz.bytes[ADDR_GUARDS]));
  endproperty
  a_bits_only_set: assert property (p_bits_only_set) // R2
    else $error("fuse bit returned to zero");

  property p_readback;
    @(posedge mclk) disable iff (!rst_n)
      (nvm_readback_command && state_r == ST_IDLE) |=>
        readback_valid && readback_data == $past(fz.bytes[readback_addr]);
  endproperty
  a_readback: assert property (p_readback) // R9
    else $error("readback data wrong");

  property p_active_hold;
    @(posedge mclk) disable iff (!rst_n)
      (state_r != ST_LOAD) |=> $stable(act_r[ADDR_COILS]);
  endproperty
  a_active_hold: assert property (p_active_hold) // R10
    else $error("active copy changed without load");

  property p_burn_done;
    @(posedge mclk) disable iff (!rst_n)
      start_r |-> ##[1:200] burn_done;
  endproperty
  a_burn_done: assert property (p_burn_done) // R4
    else $error("burn did not complete");

  property p_node_id;
    @(posedge mclk) disable iff (!rst_n)
      1'b1 |=> node_id == {$past(act_r[ADDR_STALL_NODE][3:0]), $past(pin_s2_r)};
  endproperty
  a_node_id: assert property (p_node_id) // R13
    else $error("node id composition wrong");

  property p_hold_zero;
    @(posedge mclk) disable iff (!rst_n)
      (act_r[ADDR_COILS][3:0] == HOLD_ZERO_CODE) |=> hold_current_ma == 10'd0;
  endproperty
  a_hold_zero: assert property (p_hold_zero) // R17
    else $error("hold code 15 not zero");

  property p_fallback_lsb;
    @(posedge mclk) disable iff (!rst_n)
      fallback_target[4:0] == FALLBACK_LSB_ZERO;
  endproperty
  a_fallback_lsb: assert property (p_fallback_lsb) // R21
    else $error("fallback low bits nonzero");

  c_burn: cover property (@(posedge mclk) disable iff (!rst_n) burn_done);
  c_refused: cover property (@(posedge mclk) disable iff (!rst_n) burn_refused);
  c_readback: cover property (@(posedge mclk) disable iff (!rst_n) readback_valid);
  c_sleep: cover property (@(posedge mclk) disable iff (!rst_n) sleep_request);
endmodule // otp_parameter_store

// ==== shared/otp_pkg.sv ====
// Constants, field layout and lookup tables of the fuse parameter store
package otp_pkg;
  localparam int unsigned NUM_BYTES = 8;
  localparam logic [2:0] ADDR_CLK_BIAS = 3'h0;
  localparam logic [2:0] ADDR_BUS_REF = 3'h1;
  localparam logic [2:0] ADDR_STALL_NODE = 3'h2;
  localparam logic [2:0] ADDR_COILS = 3'h3;
  localparam logic [2:0] ADDR_SPEEDS = 3'h4;
  localparam logic [2:0] ADDR_FB_HIGH = 3'h5;
  localparam logic [2:0] ADDR_FB_LOW = 3'h6;
  localparam logic [2:0] ADDR_GUARDS = 3'h7;
  localparam int unsigned USER_GUARD_BIT = 0;
  localparam int unsigned FACTORY_GUARD_BIT = 1;
  localparam logic [2:0] FACTORY_LAST_ADDR = 3'h1;
  localparam logic [10:0] FALLBACK_OFF = 11'h400;
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] HOLD_ZERO_CODE = 4'hF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [4:0] FALLBACK_LSB_ZERO = 5'h00;
  // Burn pulse length per byte
  localparam int unsigned BURN_TIME_NS = 1000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned BURN_CYCLES = (BURN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] BURN_CYC = 8'(BURN_CYCLES);
  typedef logic [9:0] milliamp_t;
  typedef logic [9:0] velocity_t;
  typedef logic [15:0] accel_t;
  typedef logic [9:0] centivolt_t;
  function automatic milliamp_t coil_ma(input logic [3:0] c);
    milliamp_t t [16] = '{10'd59, 10'd71, 10'd84, 10'd100, 10'd119, 10'd141, 10'd168,
      10'd200, 10'd238, 10'd283, 10'd336, 10'd400, 10'd476, 10'd566, 10'd673, 10'd800};
    return t[c];
  endfunction
  function automatic velocity_t top_speed(input logic [3:0] c);
    velocity_t t [16] = '{10'd99, 10'd136, 10'd167, 10'd197, 10'd213, 10'd228, 10'd243,
      10'd273, 10'd303, 10'd334, 10'd364, 10'd395, 10'd456, 10'd546, 10'd729, 10'd973};
    return t[c];
  endfunction
  function automatic accel_t ramp_rate(input logic [3:0] c);
    accel_t t [16] = '{16'd49, 16'd218, 16'd1004, 16'd3609, 16'd6228, 16'd8848, 16'd11409,
      16'd13970, 16'd16531, 16'd19092, 16'd21886, 16'd24447, 16'd27008, 16'd29570,
      16'd34925, 16'd40047};
    return t[c];
  endfunction
  // Level in units of 10 mV
  function automatic centivolt_t level_cv(input logic [3:0] c, input logic [5:0] step);
    return centivolt_t'(c) * centivolt_t'(step);
  endfunction
  localparam logic [5:0] ABS_STEP_CV = 6'd50;
  localparam logic [5:0] DEL_STEP_CV = 6'd25;
endpackage

// ==== shared/burn_if.sv ====
// Request and answer between the store core and the fuse array
`timescale 1ns/1ps
interface burn_if;
  logic start;
  logic [2:0] addr;
  logic [7:0] mask;
  logic busy;
  logic done;
  logic [7:0] bytes [8];
  modport ctrl (output start, output addr, output mask, input busy, input done, input bytes);
  modport array (input start, input addr, input mask, output busy, output done, output bytes);
endinterface

// ==== design/fuse_array.sv ====
// Eight fuse bytes, burn timing, set-only bits
`timescale 1ns/1ps
module fuse_array (
  input wire logic mclk,
  input wire logic rst_n,
  burn_if.array bus
);
  import otp_pkg::*;
  // Blank cells at power-up; reset never clears them
  logic [7:0] fuse_r [8] = '{default: BYTE_ZERO}; // R1
  logic [7:0] cnt_r;
  logic busy_r;
  logic done_r;
  logic [2:0] addr_r;
  logic [7:0] mask_r;
  assign bus.busy = busy_r;
  assign bus.done = done_r;
  assign bus.bytes = fuse_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      cnt_r <= BYTE_ZERO;
      addr_r <= ADDR_CLK_BIAS;
      mask_r <= BYTE_ZERO;
    end else begin
      done_r <= 1'b0;
      if (!busy_r && bus.start) begin
        busy_r <= 1'b1;
        cnt_r <= BURN_CYC;
        addr_r <= bus.addr;
        mask_r <= bus.mask & ~fuse_r[bus.addr]; // R3
      end else if (busy_r) begin
        cnt_r <= cnt_r - 8'd1;
        if (cnt_r == 8'd1) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  // Fuse cells are not cleared by reset: they model nonvolatile state
  always_ff @(posedge mclk) begin
    if (busy_r && cnt_r == 8'd1) begin
      fuse_r[addr_r] <= fuse_r[addr_r] | mask_r; // R2 R4
    end
  end
endmodule // fuse_array

// ==== design/param_decode.sv ====
// Decoding of active fuse bytes into drive parameters
`timescale 1ns/1ps
module param_decode (
  input wire logic [7:0] act [8],
  input wire logic [2:0] pin_node_id_bits,
  output logic [6:0] node_id,
  output otp_pkg::centivolt_t abs_cv,
  output otp_pkg::centivolt_t del_cv,
  output otp_pkg::milliamp_t run_ma,
  output otp_pkg::milliamp_t hold_ma,
  output otp_pkg::velocity_t vmax,
  output otp_pkg::velocity_t vmin,
  output otp_pkg::accel_t accel,
  output logic [15:0] fallback_pos,
  output logic fallback_en,
  output logic [1:0] microstep_resolution,
  output logic shaft_outer
);
  import otp_pkg::*;
  logic [10:0] fb;
  logic [3:0] vmin_code;
  logic [14:0] vprod;
  // Only nine target bits are fused; the two lowest are always zero
  assign fb = {act[ADDR_FB_HIGH][7:5], act[ADDR_FB_LOW][7:2], 2'b00};
  assign node_id = {act[ADDR_STALL_NODE][3:0], pin_node_id_bits}; // R12 R13
  assign abs_cv = level_cv(act[ADDR_STALL_NODE][7:4], ABS_STEP_CV); // R14
  assign del_cv = level_cv(act[ADDR_GUARDS][7:4], DEL_STEP_CV); // R15
  assign run_ma = coil_ma(act[ADDR_COILS][7:4]); // R16
  assign hold_ma = act[ADDR_COILS][3:0] == HOLD_ZERO_CODE ? 10'd0
    : coil_ma(act[ADDR_COILS][3:0]); // R17
  assign vmax = top_speed(act[ADDR_SPEEDS][7:4]); // R22
  assign vmin_code = act[ADDR_SPEEDS][3:0];
  assign vprod = 15'(vmax) * 15'(vmin_code);
  assign vmin = vmin_code == CODE_OFF ? vmax : velocity_t'(vprod >> 5); // R22
  assign accel = ramp_rate(act[ADDR_FB_HIGH][3:0]); // R23
  assign fallback_pos = {fb, FALLBACK_LSB_ZERO}; // R21
  assign fallback_en = fb != FALLBACK_OFF; // R20
  assign microstep_resolution = act[ADDR_GUARDS][3:2]; // R18
  assign shaft_outer = act[ADDR_FB_HIGH][4]; // R19
endmodule // param_decode

// ==== testbench/bus_master_model.sv ====
// Bus master model that sends burn, read-back and reload commands
`timescale 1ns/1ps
module bus_master_model (
  input wire logic mclk,
  input wire logic burn_busy,
  input wire logic burn_refused,
  input wire logic burn_done,
  input wire logic readback_valid,
  input wire logic [7:0] readback_data,
  output logic nvm_burn_command,
  output logic [2:0] burn_addr,
  output logic [7:0] burn_data,
  output logic nvm_readback_command,
  output logic [2:0] readback_addr,
  output logic defaults_reload_command
);
  initial begin
    nvm_burn_command = 1'b0;
    burn_addr = 3'h0;
    burn_data = 8'h00;
    nvm_readback_command = 1'b0;
    readback_addr = 3'h0;
    defaults_reload_command = 1'b0;
  end

  // One byte per command; next command only after the answer
  task automatic burn(input logic [2:0] a, input logic [7:0] d, output logic [2:0] ans);
    int n;
    logic busy_seen;
    logic refused_seen;
    n = 0;
    @(negedge mclk);
    nvm_burn_command = 1'b1;
    burn_addr = a;
    burn_data = d;
    // Held until taken: a load in progress delays acceptance
    do begin
      @(negedge mclk);
      n++;
    end while (burn_busy !== 1'b1 && burn_refused !== 1'b1 && n < 8);
    busy_seen = burn_busy;
    refused_seen = burn_refused;
    nvm_burn_command = 1'b0;
    // Released lines never keep the old value
    burn_addr = ~a;
    burn_data = ~d;
    while (burn_done !== 1'b1 && refused_seen !== 1'b1 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    ans = {busy_seen, refused_seen, burn_done};
  endtask

  task automatic readback(input logic [2:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(negedge mclk);
    nvm_readback_command = 1'b1;
    readback_addr = a;
    // Held until answered: a load in progress delays it
    do begin
      @(negedge mclk);
      n++;
    end while (readback_valid !== 1'b1 && n < 8);
    d = (readback_valid === 1'b1) ? readback_data : 8'hxx;
    nvm_readback_command = 1'b0;
    readback_addr = ~a;
  endtask

  task automatic reload();
    @(negedge mclk);
    defaults_reload_command = 1'b1;
    @(negedge mclk);
    defaults_reload_command = 1'b0;
  endtask
endmodule // bus_master_model

// ==== testbench/otp_parameter_store_tb.sv ====
// Self-checking bench of the fuse parameter store
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module otp_parameter_store_tb;
  import otp_pkg::*;
  typedef struct packed {
    logic [2:0] a;
    logic [7:0] d;
    logic [7:0] e;
    logic [2:0] ans;
  } step_s;
  // Accepted burn answers 3'h5 (busy then done), refused 3'h2
  step_s steps [15] = '{
    '{3'h3, 8'hE5, 8'hE5, 3'h5}, '{3'h3, 8'h1F, 8'hFF, 3'h5}, '{3'h2, 8'hA9, 8'hA9, 3'h5},
    '{3'h7, 8'h7C, 8'h7C, 3'h5}, '{3'h5, 8'h8B, 8'h8B, 3'h5}, '{3'h0, 8'h5A, 8'h5A, 3'h5},
    '{3'h1, 8'h9C, 8'h9C, 3'h5}, '{3'h6, 8'h07, 8'h07, 3'h5}, '{3'h5, 8'h10, 8'h9B, 3'h5},
    '{3'h7, 8'h02, 8'h7E, 3'h5}, '{3'h0, 8'hA5, 8'h5A, 3'h2}, '{3'h2, 8'h02, 8'hAB, 3'h5},
    '{3'h7, 8'h01, 8'h7F, 3'h5}, '{3'h4, 8'h08, 8'hF4, 3'h2}, '{3'h7, 8'h80, 8'h7F, 3'h2}};
  logic mclk = 1'b0;
  logic rst_n, nvm_burn_command, nvm_readback_command, defaults_reload_command;
  logic [2:0] burn_addr, readback_addr, pin_node_id_bits;
  logic [7:0] burn_data, readback_data, rd;
  logic bus_timeout, bus_lost_at_por, burn_busy, burn_refused, burn_done, readback_valid;
  logic [6:0] node_id;
  logic [3:0] clock_trim, bias_current_trim, voltage_ref_trim;
  logic [2:0] overheat_limit_trim, ans;
  logic bus_transceiver_on, fallback_enable, shaft_outer, sleep_request, rescue_motion_start;
  logic [9:0] stall_level_absolute, stall_level_change, run_current_ma, hold_current_ma;
  logic [9:0] top_speed_fs, floor_speed_fs;
  logic [15:0] ramp_rate_fs2, fallback_target;
  logic [1:0] microstep_resolution;
  int num_errors = 0;
  int checks_done = 0;

  always #4 mclk = ~mclk;

  otp_parameter_store dut (
    .mclk(mclk), .rst_n(rst_n), .nvm_burn_command(nvm_burn_command), .burn_addr(burn_addr),
    .burn_data(burn_data), .nvm_readback_command(nvm_readback_command),
    .readback_addr(readback_addr), .defaults_reload_command(defaults_reload_command),
    .pin_node_id_bits(pin_node_id_bits), .bus_timeout(bus_timeout),
    .bus_lost_at_por(bus_lost_at_por), .burn_busy(burn_busy), .burn_refused(burn_refused),
    .burn_done(burn_done), .readback_valid(readback_valid), .readback_data(readback_data),
    .node_id(node_id), .clock_trim(clock_trim), .bias_current_trim(bias_current_trim),
    .overheat_limit_trim(overheat_limit_trim), .voltage_ref_trim(voltage_ref_trim),
    .bus_transceiver_on(bus_transceiver_on), .stall_level_absolute(stall_level_absolute),
    .stall_level_change(stall_level_change), .run_current_ma(run_current_ma),
    .hold_current_ma(hold_current_ma), .top_speed_fs(top_speed_fs),
    .floor_speed_fs(floor_speed_fs), .ramp_rate_fs2(ramp_rate_fs2),
    .fallback_target(fallback_target), .fallback_enable(fallback_enable),
    .microstep_resolution(microstep_resolution), .shaft_outer(shaft_outer),
    .sleep_request(sleep_request), .rescue_motion_start(rescue_motion_start)
  );

  bus_master_model master (
    .mclk(mclk), .burn_busy(burn_busy), .burn_refused(burn_refused), .burn_done(burn_done),
    .readback_valid(readback_valid), .readback_data(readback_data),
    .nvm_burn_command(nvm_burn_command), .burn_addr(burn_addr), .burn_data(burn_data),
    .nvm_readback_command(nvm_readback_command), .readback_addr(readback_addr),
    .defaults_reload_command(defaults_reload_command)
  );

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Active copy needs a load cycle plus an output cycle
  task automatic settle();
    repeat (6) @(negedge mclk);
  endtask

  // Each read-back also refreshes the active copy
  task automatic run_steps(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      master.burn(steps[i].a, steps[i].d, ans);
      `CHK(ans, steps[i].ans)
      master.readback(steps[i].a, rd);
      `CHK(rd, steps[i].e)
    end
    settle();
  endtask

  initial begin
    rst_n = 1'b0;
    pin_node_id_bits = 3'h5;
    bus_timeout = 1'b1;
    bus_lost_at_por = 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    settle();
    for (int i = 0; i < NUM_BYTES; i++) begin
      master.readback(3'(i), rd);
      `CHK(rd, 8'h00)
    end
    settle();
    `CHK(run_current_ma, 10'h03B)
    `CHK(stall_level_absolute, 10'h000)
    `CHK(fallback_enable, 1'b1)
    `CHK(sleep_request, 1'b0)
    `CHK(rescue_motion_start, 1'b0)
    `CHK(node_id, 7'h05)
    // Burned speed byte stays inactive until a reload
    master.burn(3'h4, 8'hF4, ans);
    `CHK(ans, 3'h5)
    settle();
    `CHK(top_speed_fs, 10'h063)
    `CHK(floor_speed_fs, 10'h063)
    master.reload();
    settle();
    `CHK(top_speed_fs, 10'h3CD)
    `CHK(floor_speed_fs, 10'h079)
    run_steps(0, 6);
    `CHK(run_current_ma, 10'h320)
    `CHK(hold_current_ma, 10'h000)
    `CHK(stall_level_absolute, 10'h1F4)
    `CHK(stall_level_change, 10'h0AF)
    `CHK(node_id, 7'h4D)
    `CHK(microstep_resolution, 2'h3)
    `CHK(ramp_rate_fs2, 16'h5F7F)
    `CHK(fallback_enable, 1'b0)
    `CHK(fallback_target, 16'h8000)
    `CHK(shaft_outer, 1'b0)
    `CHK({clock_trim, bias_current_trim}, 8'h5A)
    `CHK({bus_transceiver_on, overheat_limit_trim, voltage_ref_trim}, 8'h9C)
    run_steps(7, 14);
    `CHK(fallback_enable, 1'b1)
    `CHK(fallback_target, 16'h8080)
    `CHK(shaft_outer, 1'b1)
    `CHK(sleep_request, 1'b1)
    `CHK(rescue_motion_start, 1'b1)
    `CHK(run_current_ma, 10'h320)
    report_and_stop();
  end

  // Whole run needs about 1800 cycles
  initial begin
    repeat (10000) @(posedge mclk);
    num_errors++;
    report_and_stop();
  end
endmodule // otp_parameter_store_tb
